/* File: tb_top.sv */
// Purpose: self-checking bench for the ULPI pin interface
// Assumes: inputs change at the falling edge
// Notes: receive traffic runs in clock-output mode only
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic resetLowPin = 1'b1;
    logic strap = 1'b0;
    logic referenceClockPin = 1'b0;
    logic [7:0] refAcc = 8'h00;
    logic recvReady = 1'b1;
    logic go = 1'b0;
    logic abort = 1'b0;
    upi_pkg::upi_send_type sendReq = '0;
    upi_pkg::upi_recv_type recvOut;
    logic [7:0] dataOut;
    wire logic [7:0] dataIn;
    logic interfaceClockPinOut, interfaceClockPinOe, dataOe, dir, nxt, stp, sendTaken;
    logic suspended, regulatorEnable, switchClosed, registerReset, clockInputMode;
    wire logic interfaceClockPinIn = interfaceClockPinOe ? interfaceClockPinOut : strap;
    logic [10:0] rxLog [$];
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] rows [4] = '{32'h0180_0180, 32'hFF00_FF00, 32'h5AA5_5AA5, 32'h7E81_7E81};
    logic [10:0] rxExp [3] = '{11'h44A, 11'h43C, 11'h7C3};
    always #4 sys_clk = ~sys_clk;
    upi_pin_interface i_dut (.sys_clk, .rst, .resetLowPin, .interfaceClockPinIn, .interfaceClockPinOut,
        .interfaceClockPinOe, .referenceClockPin, .dataIn, .dataOut, .dataOe, .dir, .nxt, .stp, .sendReq,
        .sendTaken, .recvReady, .recvOut, .suspended, .regulatorEnable, .switchClosed, .registerReset,
        .clockInputMode);
    upi_link_model i_link (.sys_clk, .iclk(interfaceClockPinOut), .go, .abort, .txBytes(24'h4A3CC3), .dir,
        .devOe(dataOe), .devData(dataOut), .nxt, .dataIn, .stp);
    // link clock for input mode: 120 toggles per 125 cycles
    always @(negedge sys_clk)
    begin
        {referenceClockPin, refAcc} <= (refAcc >= 8'h05) ? {~referenceClockPin, refAcc - 8'h05}
            : {referenceClockPin, refAcc + 8'h78};
        if (recvOut.valid === 1'b1 || recvOut.stop === 1'b1)
            rxLog.push_back(recvOut);
        cycles++;
        if (cycles == 12000)
        begin
            fails++;
            results();
        end
    end
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic sendPair(input logic [15:0] b, output logic [15:0] seen);
        for (int k = 0; k < 2; k++)
        begin
            sendReq = '{valid: 1'b1, last: k[0], data: b[15 - 8 * k -: 8]};
            repeat (40)
            begin
                @(negedge sys_clk);
                if (sendTaken === 1'b1)
                    break;
            end
            seen[15 - 8 * k -: 8] = dataOut;
        end
        sendReq = '0;
        repeat (8) @(negedge sys_clk);
    endtask
    task automatic pinPulse(input int len, input logic s, input logic [1:0] expPulses);
        logic [1:0] pulses;
        strap = s;
        resetLowPin = 1'b0;
        repeat (len) @(negedge sys_clk);
        check("suspend state", 16'h0005, {suspended, regulatorEnable, switchClosed});
        resetLowPin = 1'b1;
        pulses = 2'd0;
        repeat (10)
        begin
            @(negedge sys_clk);
            pulses += registerReset;
        end
        check("reset pulses", expPulses, pulses);
        check("clock mode", s, clockInputMode);
        check("clock pin oe", !s, interfaceClockPinOe);
    endtask
    initial
    begin
        logic [15:0] seen;
        logic p;
        int n;
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        repeat (10) @(negedge sys_clk);
        n = 0;
        p = interfaceClockPinOut;
        repeat (1250)
        begin
            @(negedge sys_clk);
            n += (interfaceClockPinOut === 1'b1 && p === 1'b0);
            p = interfaceClockPinOut;
        end
        check("clock edges", 16'h0001, 16'(n >= 599 && n <= 601));
        $display("clock test done");
        foreach (rows[r])
        begin
            sendPair(rows[r][31:16], seen);
            check("sent bytes", rows[r][15:0], seen);
            check("dir idle", 16'h0000, dir);
        end
        $display("send table done");
        abort = 1'b1;
        sendReq = '{valid: 1'b1, last: 1'b0, data: 8'h5A};
        repeat (40)
        begin
            @(negedge sys_clk);
            if (sendTaken === 1'b1)
                break;
        end
        sendReq = '0;
        repeat (8) @(negedge sys_clk);
        abort = 1'b0;
        check("abort bus", 16'h0000, {dir, dataOe, nxt});
        $display("abort test done");
        for (int k = 0; k < 2; k++)
        begin
            rxLog.delete();
            recvReady = k[0];
            go = 1'b1;
            @(negedge sys_clk);
            go = 1'b0;
            repeat (20) @(negedge sys_clk);
            recvReady = 1'b1;
            repeat (40) @(negedge sys_clk);
            check("recv count", 16'h0003, 16'(rxLog.size()));
            foreach (rxExp[i])
                check("recv byte", rxExp[i], rxLog[i]);
        end
        $display("receive test done");
        pinPulse(130, 1'b1, 2'd1);
        sendPair(16'hC33C, seen);
        check("input mode bytes", 16'hC33C, seen);
        pinPulse(115, 1'b1, 2'd0);
        pinPulse(130, 1'b0, 2'd1);
        $display("reset test done");
        results();
    end
endmodule
`default_nettype wire

/* File: upi_asserts.sv */
// Purpose: port checks of the ULPI pin interface
// Assumes: bound to upi_pin_interface, one clock domain
// Notes: sync delays are given margin, not exact depth
`timescale 1ns/1ns
`default_nettype none
module upi_asserts (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic resetLowPin,
    input wire logic interfaceClockPinOut,
    input wire logic interfaceClockPinOe,
    input wire logic dataOe,
    input wire logic dir,
    input wire logic nxt,
    input wire logic sendTaken,
    input wire upi_pkg::upi_recv_type recvOut,
    input wire logic suspended,
    input wire logic regulatorEnable,
    input wire logic switchClosed,
    input wire logic registerReset,
    input wire logic clockInputMode
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_SUSP_PWR: assert property (suspended |-> !regulatorEnable && switchClosed) else $error("power state");
    AST_SUSP_BUS: assert property (suspended |-> !dir && !dataOe) else $error("bus busy in suspend");
    AST_PIN_LOW: assert property (!resetLowPin [*6] |-> suspended) else $error("no suspend");
    AST_PIN_HIGH: assert property (resetLowPin [*6] |-> !suspended) else $error("stuck suspend");
    AST_OE_DIR: assert property (dataOe |-> dir) else $error("bus driven with dir low");
    AST_TURN: assert property ($rose(dir) |-> !dataOe) else $error("no turnaround");
    AST_TAKEN: assert property (sendTaken |-> dir && dataOe ##1 !sendTaken) else $error("taken");
    AST_CLK_OE: assert property (interfaceClockPinOe |-> !clockInputMode) else $error("clock in mode");
    AST_CLK_RATE: assert property (interfaceClockPinOe && $rose(interfaceClockPinOut) |=> ##[0:1]
        !interfaceClockPinOut) else $error("clock high too long");
    AST_LAUNCH: assert property (interfaceClockPinOe && $past(interfaceClockPinOe) && !suspended && $changed(dir)
        |-> $rose(interfaceClockPinOut)) else $error("dir off clock edge");
    AST_PULSE: assert property (registerReset |=> !registerReset) else $error("long reset pulse");
    AST_SEND_NXT: assert property (sendTaken |-> nxt) else $error("send byte without nxt");
    AST_SUSP_NXT: assert property (suspended |-> !nxt) else $error("nxt in suspend");
    AST_LAST_STOP: assert property (recvOut.last |-> recvOut.valid && recvOut.stop)
        else $error("last without stop");
    COV_SEND: cover property (sendTaken);
    COV_RECV: cover property (recvOut.valid && recvOut.last);
    COV_PIN: cover property (registerReset);
endmodule
bind upi_pin_interface upi_asserts i_asserts (.sys_clk, .rst, .resetLowPin, .interfaceClockPinOut,
    .interfaceClockPinOe, .dataOe, .dir, .nxt, .sendTaken, .recvOut, .suspended, .regulatorEnable,
    .switchClosed, .registerReset, .clockInputMode);
`default_nettype wire

/* File: upi_link_model.sv */
// Purpose: link controller on the ULPI bus, sends one command stream
// Assumes: clock-output mode, a tick is seen one edge late
// Notes: acceptance uses nxt delayed to match the late tick
`timescale 1ns/1ns
`default_nettype none
module upi_link_model (
    input wire logic sys_clk,
    input wire logic iclk,
    input wire logic go,
    input wire logic abort,
    input wire logic [23:0] txBytes,
    input wire logic dir,
    input wire logic devOe,
    input wire logic [7:0] devData,
    input wire logic nxt,
    output logic [7:0] dataIn,
    output var logic stp = 1'b0
);
    logic prev = 1'b0;
    logic nxtD = 1'b0;
    logic busy = 1'b0;
    logic [1:0] idx = 2'b00;
    logic [7:0] drive = 8'h00;
    logic [7:0] lastLvl = 8'h00;
    // undriven bus shows the inverse, so stale data never looks valid
    assign dataIn = dir ? (devOe ? devData : ~lastLvl) : drive;
    always @(posedge sys_clk)
    begin
        prev <= iclk;
        nxtD <= nxt;
        lastLvl <= dataIn;
        if (go && !busy && !dir)
        begin
            busy <= 1'b1;
            idx <= 2'b00;
            drive <= txBytes[23:16];
        end
        else if (busy && iclk && !prev)
        begin
            if (stp)
            begin
                stp <= 1'b0;
                busy <= 1'b0;
            end
            else if (nxtD && idx == 2'd2)
            begin
                stp <= 1'b1;
                drive <= 8'h00;
            end
            else if (nxtD)
            begin
                idx <= idx + 2'd1;
                drive <= (idx == 2'd0) ? txBytes[15:8] : txBytes[7:0];
            end
        end
        else if (stp && !busy && iclk && !prev)
        begin
            stp <= 1'b0;
        end
        else if (abort && devOe && iclk && !prev)
        begin
            // stop a device stream once it has data on the bus
            stp <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: upi_pin_interface.sv */
// Purpose: device-side ULPI pin logic: clocking, direction, throttle, stop, reset pin
// Assumes: all pin inputs except the reset pin are synchronous to sys_clk
// Notes: rising interface clock edges become one-cycle ticks; outside suspend all bus outputs change on a tick
//
// Contract
// - In clock-output mode drive a 60 MHz interface clock and launch all bus signals on its rising edge.
// - A clock pin strapped to the core supply rail selects clock-input mode with the clock from the link.
// - The device throttles with an active-high next signal that marks a link byte as accepted.
// - A stop during a link transmission means the byte of the previous cycle was the last one.
// - The device raises direction to own the data bus whenever it has data for the link; here only from idle while the bus reads idle.
// - With nothing to send the device holds direction low and watches the bus for link commands.
// - The shared data bus is eight bits wide and two-way, bit 0 least and bit 7 most significant.
// - While the reset pin is low the device stays suspended with its regulators disabled.
// - While the reset pin is high the device works as a normal transceiver.
// - The reset pin may change at any time and is treated as asynchronous.
// - A low pulse of at least 1 us resets all interface registers and every state machine.
// - While the reset pin is asserted the pass-through switch controls stay closed.
`timescale 1ns/1ns
`default_nettype none

module upi_pin_interface (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic resetLowPin,
    input wire logic interfaceClockPinIn,
    output logic interfaceClockPinOut,
    output logic interfaceClockPinOe,
    input wire logic referenceClockPin,
    input wire logic [upi_pkg::BUS_WIDTH-1:0] dataIn,
    output logic [upi_pkg::BUS_WIDTH-1:0] dataOut,
    output logic dataOe,
    output logic dir,
    output logic nxt,
    input wire logic stp,
    input wire upi_pkg::upi_send_type sendReq,
    output logic sendTaken,
    input wire logic recvReady,
    output var upi_pkg::upi_recv_type recvOut,
    output logic suspended,
    output logic regulatorEnable,
    output logic switchClosed,
    output logic registerReset,
    output logic clockInputMode
);

    upi_pkg::upi_state_type s;
    upi_pkg::upi_state_type next_s;

    logic pinLow;
    logic tick;
    logic [8:0] phaseSum;
    logic toggle;

    always_comb
    begin
        next_s = s;
        tick = 1'b0;
        toggle = 1'b0;
        phaseSum = {1'b0, s.phaseAcc} + {1'b0, upi_pkg::PHASE_STEP};

        // two-flop synchroniser; only the second stage is looked at
        next_s.rstMeta = resetLowPin;
        next_s.rstSync = s.rstMeta;
        pinLow = !s.rstSync;

        next_s.suspended = pinLow;
        next_s.regEnable = !pinLow;
        next_s.switchClosed = pinLow;
        next_s.regReset = 1'b0;
        next_s.sendTaken = 1'b0;
        next_s.recv.valid = 1'b0;
        next_s.recv.last = 1'b0;
        next_s.recv.stop = 1'b0;

        if (pinLow)
        begin
            // clock pin is released here so its strap level can be read
            next_s.clkInMode = interfaceClockPinIn;
            next_s.clkOe = 1'b0;
            next_s.interface_clock_pin = 1'b0;
            next_s.phaseAcc = 8'h00;
            // track the pin so a release in input mode shows no false edge
            next_s.refPrev = referenceClockPin;
            if (s.lowCount != 8'hFF)
            begin
                next_s.lowCount = s.lowCount + 8'h01;
            end
            next_s.fsm = upi_pkg::UPI_IDLE;
            next_s.dir = 1'b0;
            next_s.nxt = 1'b0;
            next_s.dataOe = 1'b0;
            next_s.dataOut = upi_pkg::BUS_IDLE;
            next_s.pendValid = 1'b0;
        end
        else
        begin
            // release seen after the synchroniser: qualify pulse length
            if (s.lowCount != 8'h00)
            begin
                next_s.regReset = (s.lowCount >= upi_pkg::MIN_RESET_PULSE_CYCLES);
                next_s.lowCount = 8'h00;
            end

            if (s.clkInMode)
            begin
                // link-sourced clock; one cycle of lag against its edge
                next_s.refPrev = referenceClockPin;
                tick = referenceClockPin && !s.refPrev;
                next_s.clkOe = 1'b0;
            end
            else
            begin
                // jitter of one sys_clk period traded for a single clock domain
                if (phaseSum >= {1'b0, upi_pkg::PHASE_MOD})
                begin
                    next_s.phaseAcc = 8'(phaseSum - {1'b0, upi_pkg::PHASE_MOD});
                    toggle = 1'b1;
                end
                else
                begin
                    next_s.phaseAcc = phaseSum[7:0];
                end
                next_s.clkOe = 1'b1;
                next_s.interface_clock_pin = s.interface_clock_pin ^ toggle;
                tick = toggle && !s.interface_clock_pin;
            end

            if (tick)
            begin
                case (s.fsm)
                    upi_pkg::UPI_IDLE:
                    begin
                        next_s.dir = 1'b0;
                        next_s.dataOe = 1'b0;
                        next_s.nxt = 1'b0;
                        if (sendReq.valid && dataIn == upi_pkg::BUS_IDLE)
                        begin
                            // turnaround cycle: direction first, data a tick later
                            next_s.dir = 1'b1;
                            next_s.fsm = upi_pkg::UPI_TURN_PHY;
                        end
                        else if (dataIn != upi_pkg::BUS_IDLE)
                        begin
                            next_s.nxt = recvReady;
                            next_s.pendValid = 1'b0;
                            next_s.fsm = upi_pkg::UPI_RECV;
                        end
                    end
                    upi_pkg::UPI_TURN_PHY:
                    begin
                        next_s.dataOe = 1'b1;
                        next_s.fsm = upi_pkg::UPI_SEND;
                        next_s.nxt = sendReq.valid;
                        if (sendReq.valid)
                        begin
                            next_s.dataOut = sendReq.data;
                            next_s.sendTaken = 1'b1;
                            if (sendReq.last)
                            begin
                                next_s.fsm = upi_pkg::UPI_TURN_LINK;
                            end
                        end
                    end
                    upi_pkg::UPI_SEND:
                    begin
                        if (stp)
                        begin
                            // link aborts: hand the bus back
                            next_s.nxt = 1'b0;
                            next_s.dir = 1'b0;
                            next_s.dataOe = 1'b0;
                            next_s.fsm = upi_pkg::UPI_IDLE;
                        end
                        else
                        begin
                            next_s.nxt = sendReq.valid;
                            if (sendReq.valid)
                            begin
                                next_s.dataOut = sendReq.data;
                                next_s.sendTaken = 1'b1;
                                if (sendReq.last)
                                begin
                                    next_s.fsm = upi_pkg::UPI_TURN_LINK;
                                end
                            end
                        end
                    end
                    upi_pkg::UPI_TURN_LINK:
                    begin
                        next_s.dir = 1'b0;
                        next_s.dataOe = 1'b0;
                        next_s.nxt = 1'b0;
                        next_s.dataOut = upi_pkg::BUS_IDLE;
                        next_s.fsm = upi_pkg::UPI_IDLE;
                    end
                    upi_pkg::UPI_RECV:
                    begin
                        if (stp)
                        begin
                            // the held byte was the one before stop
                            next_s.recv.valid = s.pendValid;
                            next_s.recv.last = s.pendValid;
                            next_s.recv.stop = 1'b1;
                            next_s.recv.data = s.pendByte;
                            next_s.pendValid = 1'b0;
                            next_s.nxt = 1'b0;
                            next_s.fsm = upi_pkg::UPI_IDLE;
                        end
                        else
                        begin
                            if (s.nxt)
                            begin
                                // hold one byte back until it is known not to be last
                                next_s.recv.valid = s.pendValid;
                                next_s.recv.data = s.pendByte;
                                next_s.pendByte = dataIn;
                                next_s.pendValid = 1'b1;
                            end
                            next_s.nxt = recvReady;
                        end
                    end
                    default:
                    begin
                        next_s.fsm = upi_pkg::UPI_IDLE;
                        next_s.dir = 1'b0;
                        next_s.nxt = 1'b0;
                        next_s.dataOe = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s <= upi_pkg::UPI_STATE_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign interfaceClockPinOut = s.interface_clock_pin;
    assign interfaceClockPinOe = s.clkOe;
    assign dataOut = s.dataOut;
    assign dataOe = s.dataOe;
    assign dir = s.dir;
    assign nxt = s.nxt;
    assign sendTaken = s.sendTaken;
    assign recvOut = s.recv;
    assign suspended = s.suspended;
    assign regulatorEnable = s.regEnable;
    assign switchClosed = s.switchClosed;
    assign registerReset = s.regReset;
    assign clockInputMode = s.clkInMode;

endmodule

`default_nettype wire

/* File: upi_pkg.sv */
// Purpose: shared constants and types for the ULPI transceiver pin interface
// Assumes: sys_clk at 125 MHz, interface clock nominally 60 MHz
// Notes: every count of cycles is derived here from a time or a rate
package upi_pkg;

    localparam int SYS_CLK_MHZ = 125;
    localparam int SYS_CLK_PERIOD_NS = 8;
    localparam int IFACE_CLK_MHZ = 60;

    // fractional divider: toggles at 2*60 per 125 system cycles
    localparam logic [7:0] PHASE_STEP = 8'(2 * IFACE_CLK_MHZ);
    localparam logic [7:0] PHASE_MOD = 8'(SYS_CLK_MHZ);

    localparam int MIN_RESET_PULSE_NS = 1000;
    localparam logic [7:0] MIN_RESET_PULSE_CYCLES =
        8'((MIN_RESET_PULSE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);

    localparam int BUS_WIDTH = 8;
    localparam logic [BUS_WIDTH-1:0] BUS_IDLE = 8'h00;

    typedef enum logic [2:0] {
        UPI_IDLE,
        UPI_TURN_PHY,
        UPI_SEND,
        UPI_TURN_LINK,
        UPI_RECV
    } upi_fsm_type;

    typedef struct packed {
        logic valid;
        logic last;
        logic [BUS_WIDTH-1:0] data;
    } upi_send_type;

    typedef struct packed {
        logic valid;
        logic last;
        logic stop;
        logic [BUS_WIDTH-1:0] data;
    } upi_recv_type;

    typedef struct packed {
        upi_fsm_type fsm;
        logic rstMeta;
        logic rstSync;
        logic [7:0] lowCount;
        logic clkInMode;
        logic [7:0] phaseAcc;
        logic interface_clock_pin;
        logic clkOe;
        logic refPrev;
        logic dir;
        logic nxt;
        logic dataOe;
        logic [BUS_WIDTH-1:0] dataOut;
        logic sendTaken;
        logic [BUS_WIDTH-1:0] pendByte;
        logic pendValid;
        upi_recv_type recv;
        logic suspended;
        logic regEnable;
        logic switchClosed;
        logic regReset;
    } upi_state_type;

    localparam upi_state_type UPI_STATE_RESET = '{fsm: UPI_IDLE, default: '0};

endpackage
